// *** logic/tcoc_in_filt.sv ***
// Purpose: Timer array package and timer input pin conditioning stage
// Assumes: Single clock at the channel operating rate, synchronous reset
// Notes: Package is shared by the channel control top
package tcoc_pkg;
   // ********************************************
   // Geometry and timing
   // ********************************************
   localparam int NCH = 6;              // 00..03, 10, 11
   localparam int U0_CH = 4;            // Channels in unit 0
   localparam int U1_CH = 2;            // Channels in unit 1
   localparam int CLK_MHZ = 200;        // Operating clock rate
   localparam int FILT_HOLD_CYC = 2;    // Equal samples needed with filter on
   // ********************************************
   // Channel indices for the master map
   // ********************************************
   localparam int CH00 = 0;
   localparam int CH01 = 1;
   localparam int CH02 = 2;
   localparam int CH03 = 3;
   localparam int CH10 = 4;
   localparam int CH11 = 5;
   // ********************************************
   // Register byte addresses
   // ********************************************
   localparam logic [7:0] ADR_LVL_U0 = 8'h00;   // Output levels unit 0
   localparam logic [7:0] ADR_LVL_U1 = 8'h04;   // Output levels unit 1
   localparam logic [7:0] ADR_GATE_U0 = 8'h08;  // Output gates unit 0
   localparam logic [7:0] ADR_GATE_U1 = 8'h0C;  // Output gates unit 1
   localparam logic [7:0] ADR_POL = 8'h10;      // Polarity, all channels
   localparam logic [7:0] ADR_MODE = 8'h14;     // Output mode select
   localparam logic [7:0] ADR_SIRQ = 8'h18;     // Start interrupt select
   localparam logic [7:0] ADR_IVCAP = 8'h1C;    // Interval or capture mode
   localparam logic [7:0] ADR_FILT = 8'h20;     // Noise filter enable
   localparam logic [7:0] ADR_PRESC = 8'h24;    // Count clock divider, 03 map
   localparam logic [7:0] ADR_INSTAT = 8'h28;   // Filtered input levels, RO
   // ********************************************
   // Field layout and reset values
   // ********************************************
   localparam int PRESC_W = 8;           // Divider field width
   localparam int M03_BIT = 8;           // Slave 03 follows 02 when set
   localparam logic [5:0] RST_CH = 6'h00;
   localparam logic [7:0] RST_PRESC = 8'h00;
endpackage

`timescale 1ns/1ps
`default_nettype none

// ********************************************
// Input synchroniser, noise filter, edge detector
// ********************************************
module tcoc_in_filt #(
   parameter int W = 6
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] pin_i,
   input wire logic [W-1:0] filt_en_i,
   output logic [W-1:0] level_o,
   output logic [W-1:0] rise_o,
   output logic [W-1:0] fall_o
);
   logic [W-1:0] sync1_q;   // First synchroniser stage, read by sync2 only
   logic [W-1:0] sync2_q;   // Synchronised pin
   logic [W-1:0] prev_q;    // Previous synchronised sample
   logic [W-1:0] acc_d;     // Accepted level, next value
   logic [W-1:0] acc_q;     // Accepted level

   // Filter on: per channel, take the sample once it held two cycles, else keep
   assign acc_d = (~filt_en_i & sync2_q) |                        // R17
                  (filt_en_i & ((~(sync2_q ^ prev_q) & sync2_q) |  // R18
                                ((sync2_q ^ prev_q) & acc_q)));

   // Pipeline: sync, filter, edge detect
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_q <= '0;
         sync2_q <= '0;
         prev_q <= '0;
         acc_q <= '0;
         rise_o <= '0;
         fall_o <= '0;
      end else begin
         sync1_q <= pin_i;                // R16
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
         acc_q <= acc_d;
         rise_o <= acc_d & ~acc_q;        // R16
         fall_o <= ~acc_d & acc_q;
      end
   end

   assign level_o = acc_q;

   // Filter on: accepted level moves only after two equal samples
   filt_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // R18
      (filt_en_i[4] && acc_d[4] != acc_q[4]) |-> (sync2_q[4] == prev_q[4]))
      else $error("Filtered level moved without two equal samples");
endmodule
`default_nettype wire

// *** logic/tcoc_chan_ctrl.sv ***
// Purpose: Channel output and input pin control of a six channel timer array
// Assumes: Classic Wishbone slave, 200 MHz clock, counters outside this block
// Notes: Channel events arrive as one-cycle pulses from the channel counters
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// R1 - Mode bit: 0 toggle, 1 set/reset
// R2 - Polarity bit: 0 positive, 1 negative
// R3 - Software sets mode, level, gate, port, start
// R4 - Output circuit never touches counting
// R5 - Gate/polarity writes act at next edge
// R6 - Master mode ignores polarity, toggles on events
// R7 - Slave mode active level from polarity
// R8 - Polarity change waits for next set/reset
// R9 - Master set delayed one count clock
// R10 - Simultaneous set and reset: reset wins
// R11 - All unit levels in one register
// R12 - Level writes only where gate is 0
// R13 - Start irq bit: interrupt and toggle at start
// R14 - Start irq bit 0: nothing at start
// R15 - Start irq ignored outside interval/capture
// R16 - Input passes filter then edge detector
// R17 - Filter off: synchronise only
// R18 - Filter on: two equal cycles required
// R19 - Unit 0 four channels, unit 1 two
// R20 - Masters 00, 02, 10 drive their slaves
// R21 - Polarity 1 swaps set and reset roles
// R22 - Level register reads back pin level
module tcoc_chan_ctrl #(
   parameter int NCH = tcoc_pkg::NCH   // R19
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   input wire logic we_i,
   input wire logic [3:0] sel_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic ack_o,
   input wire logic [NCH-1:0] chan_timer_irq_i,
   input wire logic [NCH-1:0] chan_start_trigger_i,
   input wire logic [NCH-1:0] chan_input_pin_i,
   output logic [NCH-1:0] chan_out_level_o,
   output logic [NCH-1:0] chan_out_gate_o,
   output logic [NCH-1:0] chan_timer_irq_o,
   output logic [NCH-1:0] chan_edge_rise_o,
   output logic [NCH-1:0] chan_edge_fall_o
);
   // ********************************************
   // Register state
   // ********************************************
   logic [NCH-1:0] level_q;       // Output level bits, drive the pins
   logic [NCH-1:0] level_d;
   logic [NCH-1:0] gate_q;        // Output gate bits
   logic [NCH-1:0] polarity_q;    // Polarity bits
   logic [NCH-1:0] mode_sel_q;    // Output mode select bits
   logic [NCH-1:0] start_irq_q;   // Start interrupt select bits
   logic [NCH-1:0] ivcap_q;       // Channel is interval or capture mode
   logic [NCH-1:0] filt_en_q;     // Noise filter enable
   logic [tcoc_pkg::PRESC_W-1:0] presc_q;   // Count clock divider
   logic m03_from02_q;            // Slave 03 follows master 02
   logic [tcoc_pkg::PRESC_W-1:0] div_q;     // Divider counter
   logic [NCH-1:0] pend_q;        // Master set waiting for a count clock
   logic [NCH-1:0] in_level;      // Filtered input levels
   logic [NCH-1:0] rise_w;
   logic [NCH-1:0] fall_w;

   // ********************************************
   // Bus decode
   // ********************************************
   wire req = cyc_i & stb_i & ~ack_o;   // One access per handshake
   // Writes land at the edge that sees ack high, once per access;
   // read data is still registered at the request edge
   wire take = cyc_i & stb_i & ack_o;
   wire wr = take & we_i & sel_i[0];
   wire wr_hi = take & we_i & sel_i[1];
   wire hit_lvl0 = (adr_i == tcoc_pkg::ADR_LVL_U0);
   wire hit_lvl1 = (adr_i == tcoc_pkg::ADR_LVL_U1);
   wire hit_gate0 = (adr_i == tcoc_pkg::ADR_GATE_U0);
   wire hit_gate1 = (adr_i == tcoc_pkg::ADR_GATE_U1);
   wire hit_pol = (adr_i == tcoc_pkg::ADR_POL);
   wire hit_mode = (adr_i == tcoc_pkg::ADR_MODE);
   wire hit_sirq = (adr_i == tcoc_pkg::ADR_SIRQ);
   wire hit_ivcap = (adr_i == tcoc_pkg::ADR_IVCAP);
   wire hit_filt = (adr_i == tcoc_pkg::ADR_FILT);
   wire hit_presc = (adr_i == tcoc_pkg::ADR_PRESC);
   wire hit_instat = (adr_i == tcoc_pkg::ADR_INSTAT);

   // Unit-packed view of a software write to level or gate bits
   wire [NCH-1:0] lvl_wmask = {{tcoc_pkg::U1_CH{wr & hit_lvl1}},   // R11
                               {tcoc_pkg::U0_CH{wr & hit_lvl0}}};
   wire [NCH-1:0] gate_wmask = {{tcoc_pkg::U1_CH{wr & hit_gate1}},
                                {tcoc_pkg::U0_CH{wr & hit_gate0}}};
   wire [NCH-1:0] unit_wdata = {dat_i[tcoc_pkg::U1_CH-1:0],
                                dat_i[tcoc_pkg::U0_CH-1:0]};

   // Read mux; unmapped addresses read zero
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = '0;
      if (hit_lvl0) begin
         rd_mux[tcoc_pkg::U0_CH-1:0] = level_q[tcoc_pkg::U0_CH-1:0];   // R22
      end else if (hit_lvl1) begin
         rd_mux[tcoc_pkg::U1_CH-1:0] = level_q[NCH-1:tcoc_pkg::U0_CH];
      end else if (hit_gate0) begin
         rd_mux[tcoc_pkg::U0_CH-1:0] = gate_q[tcoc_pkg::U0_CH-1:0];
      end else if (hit_gate1) begin
         rd_mux[tcoc_pkg::U1_CH-1:0] = gate_q[NCH-1:tcoc_pkg::U0_CH];
      end else if (hit_pol) begin
         rd_mux[NCH-1:0] = polarity_q;
      end else if (hit_mode) begin
         rd_mux[NCH-1:0] = mode_sel_q;
      end else if (hit_sirq) begin
         rd_mux[NCH-1:0] = start_irq_q;
      end else if (hit_ivcap) begin
         rd_mux[NCH-1:0] = ivcap_q;
      end else if (hit_filt) begin
         rd_mux[NCH-1:0] = filt_en_q;
      end else if (hit_presc) begin
         rd_mux[tcoc_pkg::PRESC_W-1:0] = presc_q;
         rd_mux[tcoc_pkg::M03_BIT] = m03_from02_q;
      end else if (hit_instat) begin
         rd_mux[NCH-1:0] = in_level;
      end
   end

   // ********************************************
   // Count clock divider
   // ********************************************
   // Enable pulse at the count clock rate; presc 0 gives every cycle
   wire count_tick = (div_q == presc_q);

   // ********************************************
   // Channel events
   // ********************************************
   // Start interrupt only in interval or capture mode with bit set
   wire [NCH-1:0] start_ev = chan_start_trigger_i & start_irq_q & ivcap_q; // R13 R14 R15
   wire [NCH-1:0] irq_eff = chan_timer_irq_i | start_ev;

   // Master set held until the next count clock, then released
   wire [NCH-1:0] dset = pend_q & {NCH{count_tick}};   // R9

   // Master to slave routing; 00 and 10 have no master
   wire [NCH-1:0] set_vec;
   assign set_vec[tcoc_pkg::CH00] = 1'b0;                                 // R20
   assign set_vec[tcoc_pkg::CH01] = dset[tcoc_pkg::CH00];
   assign set_vec[tcoc_pkg::CH02] = dset[tcoc_pkg::CH00];
   assign set_vec[tcoc_pkg::CH03] = m03_from02_q ? dset[tcoc_pkg::CH02] :
                                                   dset[tcoc_pkg::CH00];
   assign set_vec[tcoc_pkg::CH10] = 1'b0;
   assign set_vec[tcoc_pkg::CH11] = dset[tcoc_pkg::CH10];

   // Next output level of one channel
   function automatic logic lvl_next(input logic cur, input logic gate,
                                     input logic mode, input logic pol,
                                     input logic own_ev, input logic set_ev,
                                     input logic wen, input logic wbit);
      logic nxt;
      nxt = cur;
      if (gate) begin
         if (!mode) begin
            // Toggle mode ignores polarity
            if (own_ev) begin                       // R1 R6
               nxt = ~cur;
            end
         end else if (own_ev) begin
            // Own interrupt resets; wins over a coincident set
            nxt = pol;                              // R10 R21
         end else if (set_ev) begin
            // Polarity is sampled only on a set or a reset, so a change waits
            nxt = ~pol;                             // R7 R8 R2
         end
      end else if (wen) begin
         nxt = wbit;                                // R12
      end
      return nxt;
   endfunction

   // Per-channel next level; counters are untouched by any of this
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         level_d[i] = lvl_next(level_q[i], gate_q[i], mode_sel_q[i],  // R4
                               polarity_q[i], irq_eff[i], set_vec[i],
                               lvl_wmask[i], unit_wdata[i]);
      end
   end

   // ********************************************
   // Input conditioning
   // ********************************************
   tcoc_in_filt #(
      .W(NCH)
   ) u_in_filt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(chan_input_pin_i),
      .filt_en_i(filt_en_q),
      .level_o(in_level),
      .rise_o(rise_w),
      .fall_o(fall_w)
   );

   // ********************************************
   // Bus slave registers
   // ********************************************
   // Config writes land at the next edge; near an event order decides
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gate_q <= tcoc_pkg::RST_CH;
         polarity_q <= tcoc_pkg::RST_CH;
         mode_sel_q <= tcoc_pkg::RST_CH;
         start_irq_q <= tcoc_pkg::RST_CH;
         ivcap_q <= tcoc_pkg::RST_CH;
         filt_en_q <= tcoc_pkg::RST_CH;
         presc_q <= tcoc_pkg::RST_PRESC;
         m03_from02_q <= 1'b0;
      end else begin
         gate_q <= (gate_q & ~gate_wmask) | (unit_wdata & gate_wmask); // R5
         if (wr && hit_pol) begin
            polarity_q <= dat_i[NCH-1:0];                              // R5
         end
         if (wr && hit_mode) begin
            mode_sel_q <= dat_i[NCH-1:0];
         end
         if (wr && hit_sirq) begin
            start_irq_q <= dat_i[NCH-1:0];
         end
         if (wr && hit_ivcap) begin
            ivcap_q <= dat_i[NCH-1:0];
         end
         if (wr && hit_filt) begin
            filt_en_q <= dat_i[NCH-1:0];
         end
         if (wr && hit_presc) begin
            presc_q <= dat_i[tcoc_pkg::PRESC_W-1:0];
         end
         if (wr_hi && hit_presc) begin
            m03_from02_q <= dat_i[tcoc_pkg::M03_BIT];
         end
      end
   end

   // Ack one cycle after the request, read data with it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= '0;
      end else begin
         ack_o <= req;
         dat_o <= req ? rd_mux : '0;
      end
   end

   // ********************************************
   // Output and event state
   // ********************************************
   // Divider, pending sets, pin levels and registered outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_q <= '0;
         pend_q <= '0;
         level_q <= tcoc_pkg::RST_CH;
         chan_out_level_o <= tcoc_pkg::RST_CH;
         chan_out_gate_o <= tcoc_pkg::RST_CH;
         chan_timer_irq_o <= tcoc_pkg::RST_CH;
         chan_edge_rise_o <= '0;
         chan_edge_fall_o <= '0;
      end else begin
         div_q <= count_tick ? '0 : div_q + 1'b1;
         // New master event beats release of an older one
         pend_q <= (pend_q & ~dset) | irq_eff;                          // R9
         level_q <= level_d;
         chan_out_level_o <= level_d;
         chan_out_gate_o <= gate_q;
         chan_timer_irq_o <= irq_eff;                                   // R13
         chan_edge_rise_o <= rise_w;
         chan_edge_fall_o <= fall_w;
      end
   end

   // ********************************************
   // Checks
   // ********************************************
   toggle_mode_a: assert property (@(posedge clk_i) disable iff (rst_i) // R6
      (gate_q[0] && !mode_sel_q[0] && irq_eff[0]) |=> (level_q[0] != $past(level_q[0])))
      else $error("Toggle mode channel did not invert");
   gated_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // R12
      (gate_q[1] && !irq_eff[1] && !set_vec[1]) |=> $stable(level_q[1]))
      else $error("Gated channel level changed without event");
   open_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // R12
      (!gate_q[2] && lvl_wmask[2]) |=> (level_q[2] == $past(dat_i[2])))
      else $error("Level write lost on open channel");
   reset_wins_a: assert property (@(posedge clk_i) disable iff (rst_i) // R10
      (gate_q[1] && mode_sel_q[1] && irq_eff[1] && set_vec[1])
      |=> (level_q[1] == $past(polarity_q[1])))
      else $error("Set beat reset on same cycle");
   slave_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // R21
      (gate_q[1] && mode_sel_q[1] && !irq_eff[1] && set_vec[1])
      |=> (level_q[1] == !$past(polarity_q[1])))
      else $error("Slave set gave wrong level");
   pol_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // R8
      (gate_q[3] && mode_sel_q[3] && !irq_eff[3] && !set_vec[3]) |=> $stable(level_q[3]))
      else $error("Polarity change moved pin early");
   set_delay_a: assert property (@(posedge clk_i) disable iff (rst_i) // R9
      (irq_eff[0] && !pend_q[0])
      |-> (!dset[0] ##1 pend_q[0]))
      else $error("Master set not delayed");
   start_irq_a: assert property (@(posedge clk_i) disable iff (rst_i) // R15
      (!ivcap_q[2] && !chan_timer_irq_i[2]) |=> !chan_timer_irq_o[2])
      else $error("Start interrupt outside interval or capture");
   bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o)
      else $error("Ack not one cycle after request");
   readback_a: assert property (@(posedge clk_i) disable iff (rst_i) // R22
      (req && hit_lvl0) |=> (dat_o[tcoc_pkg::U0_CH-1:0] == $past(level_q[3:0])))
      else $error("Level readback differs from pin level");
   // Config write lands at the ack edge with the bus data
   write_at_ack_a: assert property (@(posedge clk_i) disable iff (rst_i) // R5
      (wr && hit_pol) |=> (polarity_q == $past(dat_i[NCH-1:0])))
      else $error("Polarity write did not land");
   // Start trigger with the select bit clear leaves pin and irq alone
   no_start_a: assert property (@(posedge clk_i) disable iff (rst_i) // R14
      (gate_q[2] && !start_irq_q[2] && chan_start_trigger_i[2] && !chan_timer_irq_i[2]
       && !set_vec[2]) |=> ($stable(level_q[2]) && !chan_timer_irq_o[2]))
      else $error("Start trigger acted with select bit clear");
   // Gated bit ignores a collective write
   gated_level_a: assert property (@(posedge clk_i) disable iff (rst_i) // R12
      (gate_q[0] && lvl_wmask[0] && !irq_eff[0]) |=> $stable(level_q[0]))
      else $error("Gated level bit took a write");
   // Unit 1 levels sit in the low bits of their own register
   unit1_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // R11 R19
      (!gate_q[4] && lvl_wmask[4]) |=> (level_q[4] == $past(dat_i[0])))
      else $error("Unit 1 level write lost");
   // Qualified event reaches the interrupt output one cycle later
   irq_pass_a: assert property (@(posedge clk_i) disable iff (rst_i) // R13
      irq_eff[2] |=> chan_timer_irq_o[2])
      else $error("Channel interrupt not passed on");
endmodule
`default_nettype wire

// *** sim/tcoc_pin_model.sv ***
// Purpose: Pin-side model that drives the timer input pins
// Assumes: Pins move only just after a rising clock edge
// Notes: A glitch bit flips its pin for as long as it is held
`timescale 1ns/1ps
`default_nettype none

// ********************************************
// Input pin source
// ********************************************
module tcoc_pin_model (
   input wire logic clk_i,
   input wire logic [5:0] want_i,
   input wire logic [5:0] glitch_i,
   output logic [5:0] pin_o
);
   // Known level from time zero, so the synchroniser never sees X
   initial pin_o = 6'h00;
   // Registered, so a pin never moves on the edge that samples it
   always @(posedge clk_i) begin
      pin_o <= want_i ^ glitch_i;
   end
endmodule
`default_nettype wire

// *** sim/tcoc_chan_ctrl_tb.sv ***
// Purpose: Self-checking bench for the channel pin control block
// Assumes: 200 MHz clock, synchronous reset held for six cycles
// Notes: One Wishbone access at a time; events are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none

module tcoc_chan_ctrl_tb;
   // ********************************************
   // Stimulus and observed signals
   // ********************************************
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rd_w;
   logic [31:0] rdat;
   logic we = 1'b0;
   logic [3:0] sel = 4'h0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic ack;
   logic [5:0] irq = 6'h00;
   logic [5:0] strt = 6'h00;
   logic [5:0] want = 6'h00;
   logic [5:0] glitch = 6'h00;
   logic [5:0] pin, lvl, gate, irq_o, rise, fall;
   logic [5:0] seen_i, seen_r, seen_f, seen_l; // OR of outputs over a window
   logic [1:0] tab [3]; // Start irq select, interval flag
   logic e;
   logic prev;
   int n_fail = 0;
   int n_compared = 0;
   int cyc_cnt = 0;

   always #2.5 clk_i = ~clk_i;

   tcoc_chan_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wdat),
      .dat_o(rd_w), .we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb), .ack_o(ack),
      .chan_timer_irq_i(irq), .chan_start_trigger_i(strt), .chan_input_pin_i(pin),
      .chan_out_level_o(lvl), .chan_out_gate_o(gate), .chan_timer_irq_o(irq_o),
      .chan_edge_rise_o(rise), .chan_edge_fall_o(fall));

   tcoc_pin_model i_pins (.clk_i(clk_i), .want_i(want), .glitch_i(glitch), .pin_o(pin));

   // ********************************************
   // Shared tasks
   // ********************************************
   // Classic cycle: hold everything until ack is sampled high
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                      input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk_i);
      adr <= a;
      we <= w;
      wdat <= d;
      sel <= s;
      cyc <= 1'b1;
      stb <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 40);
      if (n >= 40) n_fail++;
      rdat = rd_w;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(a, 1'b1, d, 4'h1);
   endtask

   task automatic rd(input logic [7:0] a);
      bus(a, 1'b0, 32'h0, 4'h1);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Drive event pulses for one cycle
   task automatic ev(input logic [5:0] i, input logic [5:0] s);
      @(posedge clk_i);
      irq <= i;
      strt <= s;
      @(posedge clk_i);
      irq <= 6'h00;
      strt <= 6'h00;
   endtask

   // Collect what the outputs did over a window
   task automatic watch(input int n);
      seen_i = 6'h00;
      seen_r = 6'h00;
      seen_f = 6'h00;
      seen_l = 6'h00;
      repeat (n) begin
         @(posedge clk_i);
         seen_i |= irq_o;
         seen_r |= rise;
         seen_f |= fall;
         seen_l |= lvl;
      end
   endtask

   task automatic tally_and_finish;
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Hang guard: whole run needs well under a thousand cycles
   always @(posedge clk_i) begin
      cyc_cnt++;
      if (cyc_cnt == 5000) begin
         n_fail++;
         tally_and_finish();
      end
   end

   // ********************************************
   // Test sequence
   // ********************************************
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      // Reset values, plus an unmapped address that reads zero
      rd(tcoc_pkg::ADR_LVL_U0);
      chk(rdat, 32'h0);
      rd(8'h30);
      chk(rdat, 32'h0);
      wr(tcoc_pkg::ADR_POL, 32'h2A);
      rd(tcoc_pkg::ADR_POL);
      chk(rdat, 32'h2A);
      $display("test registers done");
      // Gated bit ignores the collective write
      wr(tcoc_pkg::ADR_POL, 32'h01);
      wr(tcoc_pkg::ADR_GATE_U0, 32'h1);
      wr(tcoc_pkg::ADR_LVL_U0, 32'hF);
      rd(tcoc_pkg::ADR_LVL_U0);
      chk(rdat, 32'hE);
      wr(tcoc_pkg::ADR_LVL_U1, 32'h3);
      // Level lands at the ack edge; the pin shows it at the same edge
      @(posedge clk_i);
      chk(32'(lvl), 32'h3E);
      chk(32'(gate), 32'h01);
      wr(tcoc_pkg::ADR_LVL_U0, 32'h0);
      wr(tcoc_pkg::ADR_LVL_U1, 32'h0);
      $display("test collective write done");
      // Toggle mode ignores polarity; register reads pin with gate on
      ev(6'h01, 6'h00);
      watch(3);
      chk(32'(lvl[0]), 32'h1);
      rd(tcoc_pkg::ADR_LVL_U0);
      chk(rdat, 32'h1);
      $display("test toggle done");
      // Slave ch01 driven by master ch00
      wr(tcoc_pkg::ADR_POL, 32'h00);
      wr(tcoc_pkg::ADR_MODE, 32'h02);
      wr(tcoc_pkg::ADR_GATE_U0, 32'h3);
      ev(6'h01, 6'h00);
      watch(4);
      chk(32'(lvl[1]), 32'h1);
      ev(6'h02, 6'h00);
      watch(3);
      chk(32'(lvl[1]), 32'h0);
      wr(tcoc_pkg::ADR_POL, 32'h02);
      watch(3);
      chk(32'(lvl[1]), 32'h0);
      ev(6'h02, 6'h00);
      watch(3);
      chk(32'(lvl[1]), 32'h1);
      ev(6'h01, 6'h00);
      watch(4);
      chk(32'(lvl[1]), 32'h0);
      // Slave reset in the delayed set cycle: pin never goes high
      wr(tcoc_pkg::ADR_POL, 32'h00);
      @(posedge clk_i);
      irq <= 6'h01;
      @(posedge clk_i);
      irq <= 6'h02;
      @(posedge clk_i);
      irq <= 6'h00;
      watch(5);
      chk(32'(seen_l[1]), 32'h0);
      $display("test slave output done");
      // Start interrupt on ch02 for each select and mode pairing except both clear
      tab = '{2'b11, 2'b01, 2'b10};
      wr(tcoc_pkg::ADR_GATE_U0, 32'h7);
      foreach (tab[k]) begin
         wr(tcoc_pkg::ADR_SIRQ, {29'h0, tab[k][1], 2'h0});
         wr(tcoc_pkg::ADR_IVCAP, {29'h0, tab[k][0], 2'h0});
         e = &tab[k];
         prev = lvl[2];
         ev(6'h00, 6'h04);
         watch(4);
         chk(32'(seen_i[2]), 32'(e));
         chk(32'(lvl[2]), 32'(prev ^ e));
      end
      $display("test start interrupt done");
      // Slave ch03 follows master ch02, not ch00, when selected
      bus(tcoc_pkg::ADR_PRESC, 1'b1, 32'h100, 4'h3);
      wr(tcoc_pkg::ADR_MODE, 32'h08);
      wr(tcoc_pkg::ADR_GATE_U0, 32'h8);
      ev(6'h01, 6'h00);
      watch(4);
      chk(32'(lvl[3]), 32'h0);
      ev(6'h04, 6'h00);
      watch(4);
      chk(32'(lvl[3]), 32'h1);
      $display("test master map done");
      // Input ch10: filter off passes a glitch, filter on drops it
      want <= 6'h10;
      watch(7);
      chk(32'(seen_r[4]), 32'h1);
      rd(tcoc_pkg::ADR_INSTAT);
      chk(rdat & 32'h10, 32'h10);
      want <= 6'h00;
      watch(7);
      chk(32'(seen_f[4]), 32'h1);
      for (int f = 0; f < 2; f++) begin
         wr(tcoc_pkg::ADR_FILT, f ? 32'h10 : 32'h0);
         @(posedge clk_i);
         glitch <= 6'h10;
         @(posedge clk_i);
         glitch <= 6'h00;
         watch(8);
         chk(32'(seen_r[4]), f ? 32'h0 : 32'h1);
      end
      want <= 6'h10;
      watch(8);
      chk(32'(seen_r[4]), 32'h1);
      // Filter is per channel: a busy neighbour must not stall ch10
      want <= 6'h00;
      seen_f = 6'h00;
      repeat (10) begin
         @(posedge clk_i);
         glitch <= glitch ^ 6'h20;
         seen_f |= fall;
      end
      chk(32'(seen_f[4]), 32'h1);
      $display("test input filter done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
